// ==== dsop_ports.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Reset loads all four mixed-port latches with one.
// - PWM drives mixed bit two, watchdog drives mixed bit three.
// - Reads of segment and digit ports return latch contents.
// - Reset clears both segment port latches to zero.
// - Segment pins show display data only while latch is zero.
// - Segment writes ignored while display enabled; accepted only in blanking.
// - Segment and general six/seven bits set, cleared, tested via L register.
// - Reset clears all four digit port latches to zero.
// - Sixteen digit pins show digit signal only while latch is zero.
// - Digit port writes act even while display is enabled.
// - Conversion output writes eight bits to plain ports one and two together.
// - In key-scan mode status bit three at address nine is key input.
module dsop_ports (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire dsop_pkg::dsop_io_type io_req,
  input wire dsop_pkg::dsop_bit_type bit_req,
  input wire dsop_pkg::dsop_conv_type conv_req,
  output logic [3:0] io_rdata,
  output logic bit_test_q,
  input wire logic pwm_n,
  input wire logic watchdog_n,
  input wire logic display_enable,
  input wire logic key_scan_mode,
  input wire logic [7:0] seg_data,
  input wire logic [15:0] digit_data,
  input wire logic key_pin,
  input wire logic [3:0] mixed_pin_in,
  input wire logic [3:0] six_pin_in,
  input wire logic [3:0] seven_pin_in,
  output logic [3:0] mixed_pin_out,
  output logic [3:0] mixed_pin_oe,
  output logic [7:0] seg_pin,
  output logic [15:0] digit_pin,
  output logic [3:0] six_pin_out,
  output logic [3:0] six_pin_oe,
  output logic [3:0] seven_pin_out,
  output logic [3:0] seven_pin_oe,
  output logic [3:0] out_one_pin,
  output logic [3:0] out_two_pin
);
  import dsop_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] mixed_s1_q, mixed_s2_q, six_s1_q, six_s2_q, seven_s1_q, seven_s2_q;
  logic key_s1_q, key_s2_q, disp_s1_q, disp_s2_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mixed_s1_q <= NIBBLE_ZERO;
      mixed_s2_q <= NIBBLE_ZERO;
      six_s1_q <= NIBBLE_ZERO;
      six_s2_q <= NIBBLE_ZERO;
      seven_s1_q <= NIBBLE_ZERO;
      seven_s2_q <= NIBBLE_ZERO;
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      disp_s1_q <= 1'b0;
      disp_s2_q <= 1'b0;
    end else if (clk_en) begin
      mixed_s1_q <= mixed_pin_in;
      mixed_s2_q <= mixed_s1_q;
      six_s1_q <= six_pin_in;
      six_s2_q <= six_s1_q;
      seven_s1_q <= seven_pin_in;
      seven_s2_q <= seven_s1_q;
      key_s1_q <= key_pin;
      key_s2_q <= key_s1_q;
      disp_s1_q <= display_enable;
      disp_s2_q <= disp_s1_q;
    end
  end

  // ----------------------------------------
  // Latches
  // ----------------------------------------
  logic [3:0] mixed_q, mixed_d, seg_lo_q, seg_lo_d, seg_hi_q, seg_hi_d;
  logic [3:0] six_q, six_d, seven_q, seven_d, one_q, one_d, two_q, two_d;
  logic [3:0] digit_q [DIGIT_PORTS];

  wire wr_hit = io_req.wr;
  // Segment latches are locked out while the display scans
  wire seg_wr_ok = ~disp_s2_q;
  wire [2:0] bsel = bit_req.l_reg[4:2];
  wire [1:0] bidx = bit_req.l_reg[1:0];
  wire bset = (bit_req.op == BIT_SET);
  wire bclr = (bit_req.op == BIT_CLEAR);
  wire [3:0] bmask = 4'h1 << bidx;

  function automatic logic [3:0] bit_apply(input logic [3:0] cur, input logic hit);
    bit_apply = cur;
    if (hit && bset) begin
      bit_apply = cur | bmask;
    end else if (hit && bclr) begin
      bit_apply = cur & ~bmask;
    end
  endfunction

  assign mixed_d = (wr_hit && io_req.addr == ADDR_MIXED) ? io_req.data : mixed_q;
  assign seg_lo_d = !seg_wr_ok ? seg_lo_q :
                    (wr_hit && io_req.addr == ADDR_SEG_LOW) ? io_req.data :
                    bit_apply(seg_lo_q, bsel == BSEL_SEG_LOW);
  assign seg_hi_d = !seg_wr_ok ? seg_hi_q :
                    (wr_hit && io_req.addr == ADDR_SEG_HIGH) ? io_req.data :
                    bit_apply(seg_hi_q, bsel == BSEL_SEG_HIGH);
  assign six_d = (wr_hit && io_req.addr == ADDR_GEN_SIX) ? io_req.data :
                 bit_apply(six_q, bsel == BSEL_GEN_SIX);
  assign seven_d = (wr_hit && io_req.addr == ADDR_GEN_SEVEN) ? io_req.data :
                   bit_apply(seven_q, bsel == BSEL_GEN_SEVEN);
  // Conversion output updates both plain ports in one cycle
  assign one_d = conv_req.wr ? conv_req.data[3:0] :
                 (wr_hit && io_req.addr == ADDR_OUT_ONE) ? io_req.data : one_q;
  assign two_d = conv_req.wr ? conv_req.data[7:4] :
                 (wr_hit && io_req.addr == ADDR_OUT_TWO) ? io_req.data : two_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mixed_q <= MIXED_RESET;
      seg_lo_q <= SEG_RESET;
      seg_hi_q <= SEG_RESET;
      six_q <= GEN_RESET;
      seven_q <= GEN_RESET;
      one_q <= PLAIN_RESET;
      two_q <= PLAIN_RESET;
    end else if (clk_en) begin
      mixed_q <= mixed_d;
      seg_lo_q <= seg_lo_d;
      seg_hi_q <= seg_hi_d;
      six_q <= six_d;
      seven_q <= seven_d;
      one_q <= one_d;
      two_q <= two_d;
    end
  end

  // ----------------------------------------
  // Digit ports, written regardless of display state
  // ----------------------------------------
  for (genvar g = 0; g < DIGIT_PORTS; g++) begin : g_digit
    wire hit = wr_hit && (io_req.addr == ADDR_DIGIT_A + 5'(g));
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        digit_q[g] <= DIGIT_RESET;
      end else if (clk_en && hit) begin
        digit_q[g] <= io_req.data;
      end
    end
  end

  // ----------------------------------------
  // Read-back and bit test
  // ----------------------------------------
  logic [3:0] rd_mux;
  wire [3:0] status_nine = {key_scan_mode & key_s2_q, 3'h0};
  wire [3:0] seg_sel_bits = bsel == BSEL_SEG_LOW ? seg_lo_q :
                            bsel == BSEL_SEG_HIGH ? seg_hi_q :
                            bsel == BSEL_GEN_SIX ? six_s2_q : seven_s2_q;
  wire test_bit = seg_sel_bits[bidx];
  wire is_digit = io_req.addr >= ADDR_DIGIT_A && io_req.addr <= ADDR_DIGIT_D;
  wire [1:0] dsel = 2'(io_req.addr - ADDR_DIGIT_A);

  always_comb begin
    rd_mux = NIBBLE_ZERO;
    if (is_digit) begin
      rd_mux = digit_q[dsel];
    end else begin
      unique case (io_req.addr)
        ADDR_MIXED: rd_mux = mixed_s2_q;
        ADDR_SEG_LOW: rd_mux = seg_lo_q;
        ADDR_SEG_HIGH: rd_mux = seg_hi_q;
        ADDR_GEN_SIX: rd_mux = six_s2_q;
        ADDR_GEN_SEVEN: rd_mux = seven_s2_q;
        ADDR_STATUS_NINE: rd_mux = status_nine;
        default: rd_mux = NIBBLE_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive: mixed-port latch one releases pin to alternate
  // ----------------------------------------
  logic [3:0] alt_mixed;
  assign alt_mixed = {watchdog_n, pwm_n, 2'b11};
  wire [15:0] digit_flat = {digit_q[3], digit_q[2], digit_q[1], digit_q[0]};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_rdata <= NIBBLE_ZERO;
      bit_test_q <= 1'b0;
      mixed_pin_out <= MIXED_RESET;
      mixed_pin_oe <= NIBBLE_ZERO;
      seg_pin <= 8'h00;
      digit_pin <= 16'h0000;
      six_pin_out <= GEN_RESET;
      six_pin_oe <= NIBBLE_ZERO;
      seven_pin_out <= GEN_RESET;
      seven_pin_oe <= NIBBLE_ZERO;
      out_one_pin <= PLAIN_RESET;
      out_two_pin <= PLAIN_RESET;
    end else if (clk_en) begin
      if (io_req.rd) begin
        io_rdata <= rd_mux;
      end
      if (bit_req.op == BIT_TEST) begin
        bit_test_q <= test_bit;
      end
      mixed_pin_out <= mixed_q & alt_mixed;
      mixed_pin_oe <= ~(mixed_q & alt_mixed);
      // Latch zero lets display data through; a one forces the pin on
      seg_pin <= {seg_hi_q, seg_lo_q} | (disp_s2_q ? seg_data : 8'h00);
      digit_pin <= digit_flat | (disp_s2_q ? digit_data : 16'h0000);
      six_pin_out <= six_q;
      six_pin_oe <= ~six_q;
      seven_pin_out <= seven_q;
      seven_pin_oe <= ~seven_q;
      out_one_pin <= one_q;
      out_two_pin <= two_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mixed_reset_ones: assert property (@(posedge clk) $fell(reset) |-> mixed_q == MIXED_RESET)
    else $error("mixed latch not all ones after reset");
  a_seg_blank_lock: assert property (@(posedge clk) disable iff (reset)
    clk_en && disp_s2_q |=> $stable({seg_hi_q, seg_lo_q}))
    else $error("segment latch changed while display enabled");
  a_digit_write_live: assert property (@(posedge clk) disable iff (reset)
    clk_en && io_req.wr && io_req.addr == ADDR_DIGIT_A |=> digit_q[0] == $past(io_req.data))
    else $error("digit write lost");
  a_conv_both_ports: assert property (@(posedge clk) disable iff (reset)
    clk_en && conv_req.wr |=> {two_q, one_q} == $past(conv_req.data))
    else $error("conversion output not on both ports");
  a_pwm_pin_route: assert property (@(posedge clk) disable iff (reset)
    clk_en && mixed_q[PWM_BIT] |=> mixed_pin_out[PWM_BIT] == $past(pwm_n))
    else $error("pwm not routed to bit two");
  a_wdt_pin_route: assert property (@(posedge clk) disable iff (reset)
    clk_en && mixed_q[WDT_BIT] |=> mixed_pin_out[WDT_BIT] == $past(watchdog_n))
    else $error("watchdog not routed to bit three");
  a_seg_readback: assert property (@(posedge clk) disable iff (reset)
    clk_en && io_req.rd && io_req.addr == ADDR_SEG_LOW |=> io_rdata == $past(seg_lo_q))
    else $error("segment read-back wrong");
  a_bit_clear_six: assert property (@(posedge clk) disable iff (reset)
    clk_en && !io_req.wr && bclr && bsel == BSEL_GEN_SIX |=> six_q[$past(bidx)] == 1'b0)
    else $error("indirect bit clear failed");
  a_key_status: assert property (@(posedge clk) disable iff (reset)
    clk_en && io_req.rd && io_req.addr == ADDR_STATUS_NINE && !key_scan_mode
    |=> io_rdata[KEY_BIT] == 1'b0)
    else $error("key status shown outside key-scan mode");

endmodule

`default_nettype wire

// ==== dsop_pkg.sv ====
package dsop_pkg;

  // ----------------------------------------
  // Port addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_OUT_ONE = 5'h01;
  localparam logic [4:0] ADDR_OUT_TWO = 5'h02;
  localparam logic [4:0] ADDR_MIXED = 5'h03;
  localparam logic [4:0] ADDR_SEG_LOW = 5'h04;
  localparam logic [4:0] ADDR_SEG_HIGH = 5'h05;
  localparam logic [4:0] ADDR_GEN_SIX = 5'h06;
  localparam logic [4:0] ADDR_GEN_SEVEN = 5'h07;
  localparam logic [4:0] ADDR_STATUS_NINE = 5'h09;
  localparam logic [4:0] ADDR_DIGIT_A = 5'h0A;
  localparam logic [4:0] ADDR_DIGIT_D = 5'h0D;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [3:0] MIXED_RESET = 4'hF;
  localparam logic [3:0] SEG_RESET = 4'h0;
  localparam logic [3:0] DIGIT_RESET = 4'h0;
  localparam logic [3:0] PLAIN_RESET = 4'h0;
  localparam logic [3:0] GEN_RESET = 4'hF;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam int PWM_BIT = 2;
  localparam int WDT_BIT = 3;
  localparam int KEY_BIT = 3;
  localparam int DIGIT_PORTS = 4;
  // Bit-addressed ports: L[4:2] picks the port, L[1:0] the bit
  localparam logic [2:0] BSEL_SEG_LOW = 3'h0;
  localparam logic [2:0] BSEL_SEG_HIGH = 3'h1;
  localparam logic [2:0] BSEL_GEN_SIX = 3'h2;
  localparam logic [2:0] BSEL_GEN_SEVEN = 3'h3;

  typedef enum logic [1:0] {
    BIT_NONE = 2'b00,
    BIT_SET = 2'b01,
    BIT_CLEAR = 2'b10,
    BIT_TEST = 2'b11
  } dsop_bitop_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [3:0] data;
  } dsop_io_type;

  typedef struct packed {
    dsop_bitop_type op;
    logic [4:0] l_reg;
  } dsop_bit_type;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } dsop_conv_type;

endpackage

// ==== dsop_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsop_far_side (
  input wire logic [3:0] mixed_pin_out,
  input wire logic [3:0] mixed_pin_oe,
  input wire logic [3:0] six_pin_out,
  input wire logic [3:0] six_pin_oe,
  input wire logic [3:0] seven_pin_out,
  input wire logic [3:0] seven_pin_oe,
  input wire logic key_press,
  output logic [3:0] mixed_pin_in,
  output logic [3:0] six_pin_in,
  output logic [3:0] seven_pin_in,
  output logic key_pin
);
  // ----------------------------------------
  // Open-drain wires with board pull-ups
  // ----------------------------------------
  // Released pins float high, so a latch of one hands the wire to the alternate source
  assign mixed_pin_in = (mixed_pin_oe & mixed_pin_out) | ~mixed_pin_oe;
  assign six_pin_in = (six_pin_oe & six_pin_out) | ~six_pin_oe;
  assign seven_pin_in = (seven_pin_oe & seven_pin_out) | ~seven_pin_oe;
  assign key_pin = key_press;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dsop_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  dsop_io_type io_req = '0;
  dsop_bit_type bit_req = '0;
  dsop_conv_type conv_req = '0;
  logic pwm_n = 1'b1;
  logic watchdog_n = 1'b1;
  logic display_enable = 1'b0;
  logic key_scan_mode = 1'b0;
  logic key_press = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] seg_data = 8'h00;
  logic [15:0] digit_data = 16'h0000;
  logic [3:0] io_rdata, mixed_pin_in, six_pin_in, seven_pin_in, mixed_pin_out, mixed_pin_oe;
  logic [3:0] six_pin_out, six_pin_oe, seven_pin_out, seven_pin_oe, out_one_pin, out_two_pin;
  logic [7:0] seg_pin;
  logic [15:0] digit_pin;
  logic bit_test_q, key_pin;
  logic [3:0] rd;
  int miscompares = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  dsop_ports dsop_ports_i (.clk(clk), .reset(reset), .clk_en(clk_en), .io_req(io_req), .bit_req(bit_req),
    .conv_req(conv_req), .io_rdata(io_rdata), .bit_test_q(bit_test_q), .pwm_n(pwm_n), .watchdog_n(watchdog_n),
    .display_enable(display_enable), .key_scan_mode(key_scan_mode), .seg_data(seg_data),
    .digit_data(digit_data), .key_pin(key_pin), .mixed_pin_in(mixed_pin_in), .six_pin_in(six_pin_in),
    .seven_pin_in(seven_pin_in), .mixed_pin_out(mixed_pin_out), .mixed_pin_oe(mixed_pin_oe),
    .seg_pin(seg_pin), .digit_pin(digit_pin), .six_pin_out(six_pin_out), .six_pin_oe(six_pin_oe),
    .seven_pin_out(seven_pin_out), .seven_pin_oe(seven_pin_oe), .out_one_pin(out_one_pin),
    .out_two_pin(out_two_pin));
  dsop_far_side dsop_far_side_i (.mixed_pin_out(mixed_pin_out), .mixed_pin_oe(mixed_pin_oe),
    .six_pin_out(six_pin_out), .six_pin_oe(six_pin_oe), .seven_pin_out(seven_pin_out),
    .seven_pin_oe(seven_pin_oe), .key_press(key_press), .mixed_pin_in(mixed_pin_in),
    .six_pin_in(six_pin_in), .seven_pin_in(seven_pin_in), .key_pin(key_pin));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic io_op(input logic wr, input logic [4:0] addr, input logic [3:0] data);
    @(negedge clk);
    io_req <= '{wr: wr, rd: ~wr, addr: addr, data: data};
    @(negedge clk);
    io_req <= '0;
    rd = io_rdata;
  endtask
  task automatic bit_op(input dsop_bitop_type op, input logic [2:0] port, input logic [1:0] b);
    @(negedge clk);
    bit_req <= '{op: op, l_reg: {port, b}};
    @(negedge clk);
    bit_req <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait across the display-enable synchroniser lag
  task automatic wait_pins(input string name, input logic dig, input logic [15:0] exp);
    int i;
    for (i = 0; i < 10 && (dig ? digit_pin : {8'h00, seg_pin}) !== exp; i++) @(negedge clk);
    check(name, exp, dig ? digit_pin : {8'h00, seg_pin});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    settle(1);
    check("mixed_out", 16'h000F, mixed_pin_out);
    check("mixed_oe", 16'h0000, mixed_pin_oe);
    check("seg_pin", 16'h0000, seg_pin);
    check("digit_pin", 16'h0000, digit_pin);
    io_op(1'b0, ADDR_SEG_HIGH, 4'h0);
    check("seg_high_read", 16'h0000, rd);
    io_op(1'b0, ADDR_DIGIT_D, 4'h0);
    check("digit_d_read", 16'h0000, rd);
    pwm_n = 1'b0;
    watchdog_n = 1'b0;
    settle(3);
    check("mixed_level_alt", 16'h0003, mixed_pin_in);
    pwm_n = 1'b1;
    watchdog_n = 1'b1;
    io_op(1'b1, ADDR_MIXED, 4'hB);
    settle(2);
    check("mixed_level_latch", 16'h000B, mixed_pin_in);
    io_op(1'b1, ADDR_MIXED, 4'hF);
    settle(4);
    io_op(1'b0, ADDR_MIXED, 4'h0);
    check("mixed_read_released", 16'h000F, rd);
    io_op(1'b1, ADDR_SEG_LOW, 4'h9);
    io_op(1'b0, ADDR_SEG_LOW, 4'h0);
    check("seg_low_read", 16'h0009, rd);
    seg_data = 8'hF0;
    settle(2);
    check("seg_pin_blank", 16'h0009, seg_pin);
    display_enable = 1'b1;
    wait_pins("seg_pin_shown", 1'b0, 16'h00F9);
    io_op(1'b1, ADDR_SEG_LOW, 4'h6);
    bit_op(BIT_SET, BSEL_SEG_LOW, 2'd1);
    io_op(1'b0, ADDR_SEG_LOW, 4'h0);
    check("seg_low_locked", 16'h0009, rd);
    display_enable = 1'b0;
    settle(5);
    bit_op(BIT_SET, BSEL_SEG_LOW, 2'd1);
    bit_op(BIT_CLEAR, BSEL_SEG_LOW, 2'd0);
    io_op(1'b0, ADDR_SEG_LOW, 4'h0);
    check("seg_low_bits", 16'h000A, rd);
    bit_op(BIT_TEST, BSEL_SEG_LOW, 2'd3);
    check("seg_test_one", 16'h0001, bit_test_q);
    bit_op(BIT_TEST, BSEL_SEG_LOW, 2'd2);
    check("seg_test_zero", 16'h0000, bit_test_q);
    bit_op(BIT_CLEAR, BSEL_GEN_SIX, 2'd1);
    settle(4);
    check("six_level", 16'h000D, six_pin_in);
    bit_op(BIT_TEST, BSEL_GEN_SIX, 2'd1);
    check("six_test", 16'h0000, bit_test_q);
    bit_op(BIT_CLEAR, BSEL_GEN_SEVEN, 2'd3);
    settle(4);
    check("seven_level", 16'h0007, seven_pin_in);
    display_enable = 1'b1;
    digit_data = 16'h0F00;
    io_op(1'b1, ADDR_DIGIT_A, 4'h5);
    wait_pins("digit_pin_mix", 1'b1, 16'h0F05);
    io_op(1'b0, ADDR_DIGIT_A, 4'h0);
    check("digit_a_read", 16'h0005, rd);
    @(negedge clk);
    conv_req <= '{wr: 1'b1, data: 8'hA5};
    @(negedge clk);
    conv_req <= '0;
    settle(2);
    check("out_one", 16'h0005, out_one_pin);
    check("out_two", 16'h000A, out_two_pin);
    key_scan_mode = 1'b1;
    key_press = 1'b1;
    settle(4);
    io_op(1'b0, ADDR_STATUS_NINE, 4'h0);
    check("key_status", 16'h0001, rd[KEY_BIT]);
    io_op(1'b0, 5'h10, 4'h0);
    check("unassigned_read", 16'h0000, rd);
    // Enable low must freeze every latch, including plain ports
    clk_en = 1'b0;
    io_op(1'b1, ADDR_OUT_ONE, 4'h3);
    settle(2);
    check("out_one_frozen", 16'h0005, out_one_pin);
    clk_en = 1'b1;
    settle(2);
    check("out_one_resumed", 16'h0005, out_one_pin);
    give_verdict();
  end
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
